// [design/ecu_opstate_pkg.sv]
package ecu_opstate_pkg;

    // one-hot operating states
    typedef enum logic [6:0] {
        ST_SLEEP      = 7'h01,
        ST_RAMPUP     = 7'h02,
        ST_NORMAL     = 7'h04,
        ST_AFTERRUN   = 7'h08,
        ST_AR_RESET   = 7'h10,
        ST_POWER_DOWN = 7'h20,
        ST_WAKE_CLEAR = 7'h40
    } state_type;

    // register byte addresses
    localparam logic [3:0] ADDR_OPERATION_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_COMMAND_ZERO     = 4'h4;
    localparam logic [3:0] ADDR_OPERATION_STATUS = 4'h8;

    // operation_config_reg fields
    localparam int CFG_AFTERRUN_ENABLE = 0;
    localparam int CFG_AFTERRUN_RESET  = 1;
    localparam int CFG_MAIN_RELAY      = 2;
    // command_reg_zero fields
    localparam int CMD_WAKE_CLEAR      = 0;
    // operation_status_reg fields
    localparam int STAT_STATE_LSB      = 0;
    localparam int STAT_OPERATING_MODE = 8;
    localparam int STAT_WAKE_REQUEST   = 9;
    localparam int STAT_MAIN_RELAY     = 10;
    localparam int STAT_KEY            = 11;

    // reset values
    localparam logic RST_AFTERRUN_ENABLE = 1'b0;
    localparam logic RST_AFTERRUN_RESET  = 1'b0;
    localparam logic RST_MAIN_RELAY      = 1'b0;
    localparam logic RST_WAKE_CLEAR_CMD  = 1'b0;

    // cycle counts
    localparam logic [2:0] POR_SETTLE_CYCLES  = 3'h4;
    localparam logic [2:0] WAKE_CLEAR_CYCLES  = 3'h7;

    // positions of the synchronised inputs
    localparam int IN_KEY      = 0;
    localparam int IN_WAKE_PIN = 1;
    localparam int IN_CAN_WAKE = 2;
    localparam int IN_EOT_WAKE = 3;
    localparam int IN_V5V_OK   = 4;
    localparam int IN_BAT_HIGH = 5;
    localparam int IN_RAMPUP_TIMER_OVERFLOW    = 6;
    localparam int IN_POWERDOWN_COUNTER_OVERFLOW    = 7;
    localparam int IN_SECURE_SHUTOFF_TIMER_OVERFLOW  = 8;
    localparam int IN_POWERDOWN_TIMER_OVERFLOW   = 9;
    localparam int IN_COUNT    = 10;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [design/pin_sync_if.sv]
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 10);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport owner  (output raw, input clean);
    modport filter (input raw, output clean);
endinterface

// [design/pin_sync_filter.sv]
`timescale 1ns/1ps
module pin_sync_filter #(
    parameter int W = 10
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    pin_sync_if.filter       pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } sync_state_type;

    sync_state_type r_q;
    sync_state_type r_d;

    // s1 feeds only s2; a bit changes once s2 and s3 agree
    always_comb begin
        r_d    = r_q;
        r_d.s1 = pins.raw;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        for (int i = 0; i < W; i++) begin
            if (r_q.s2[i] == r_q.s3[i]) begin
                r_d.clean[i] = r_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign pins.clean = r_q.clean;
endmodule

// [design/ecu_operation_state_machine.sv]
// Notes on behaviour
// - exactly seven operating states exist
// - sleep keeps the main relay off
// - reset with key and wake low gives sleep
// - reset with key or wake high gives ramp-up
// - sleep leaves for ramp-up on key or wake
// - ramp-up returns to sleep when both low
// - ramp-up timeout with wake only goes wake clear
// - ramp-up to normal once supply is good
// - normal relay follows battery level or relay bit
// - key low with afterrun enabled enters afterrun
// - afterrun keeps the unit supplied
// - afterrun enable cleared with wake low ends in sleep
// - power-down overflows lead to general power down
// - key back with reset bit clear resumes normal
// - key back with reset bit set: afterrun reset
// - afterrun reset lasts one clock, then normal
// - power down cuts supplies, holds relay, runs timer
// - power-down timer overflow goes to wake clear
// - wake clear runs the clear command behaviour
// - wake clear exits by key level
// - wake request ORs pin, bus and timer wakes
// - status bit shows normal or afterrun
`timescale 1ns/1ps
module ecu_operation_state_machine (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        keyAboveThreshold,
    input  wire logic        pinWakeSignal,
    input  wire logic        canWakeSignal,
    input  wire logic        engineOffTimerWake,
    input  wire logic        ecu5vSupplyOk,
    input  wire logic        batterySupplyHigh,
    input  wire logic        rampupTimerOverflow,
    input  wire logic        powerdownCounterOverflow,
    input  wire logic        secureShutoffTimerOverflow,
    input  wire logic        powerdownTimerOverflow,
    output logic             mainRelayOn,
    output logic             ecu5vSupplyEn,
    output logic             trackerSupplyEn,
    output logic             externalFunctionsEn,
    output logic             powerdownTimerRun,
    output logic             wakeClearActive,
    output logic             wakeClearMode,
    output logic             afterrunResetActive,
    output logic             operatingModeBit,
    output logic [6:0]       stateCode
);
    typedef struct packed {
        ecu_opstate_pkg::state_type state;
        logic                       porPending;
        logic [2:0]                 porCount;
        logic [2:0]                 clrCount;
        logic                       afterrunEnable;
        logic                       afterrunReset;
        logic                       relayRequest;
        logic                       wakeClearCmd;
        logic                       relayOn;
        logic                       awHeld;
        logic [3:0]                 awAddr;
        logic                       wHeld;
        logic [31:0]                wData;
        logic [3:0]                 wStrb;
        logic                       bValid;
        logic [1:0]                 bResp;
        logic                       rValid;
        logic [31:0]                rData;
        logic [1:0]                 rResp;
    } core_state_type;

    core_state_type r_q;
    core_state_type r_d;

    pin_sync_if #(.W(ecu_opstate_pkg::IN_COUNT)) pins ();

    assign pins.raw[ecu_opstate_pkg::IN_KEY]      = keyAboveThreshold;
    assign pins.raw[ecu_opstate_pkg::IN_WAKE_PIN] = pinWakeSignal;
    assign pins.raw[ecu_opstate_pkg::IN_CAN_WAKE] = canWakeSignal;
    assign pins.raw[ecu_opstate_pkg::IN_EOT_WAKE] = engineOffTimerWake;
    assign pins.raw[ecu_opstate_pkg::IN_V5V_OK]   = ecu5vSupplyOk;
    assign pins.raw[ecu_opstate_pkg::IN_BAT_HIGH] = batterySupplyHigh;
    assign pins.raw[ecu_opstate_pkg::IN_RAMPUP_TIMER_OVERFLOW]    = rampupTimerOverflow;
    assign pins.raw[ecu_opstate_pkg::IN_POWERDOWN_COUNTER_OVERFLOW]    = powerdownCounterOverflow;
    assign pins.raw[ecu_opstate_pkg::IN_SECURE_SHUTOFF_TIMER_OVERFLOW]  = secureShutoffTimerOverflow;
    assign pins.raw[ecu_opstate_pkg::IN_POWERDOWN_TIMER_OVERFLOW]   = powerdownTimerOverflow;

    pin_sync_filter #(.W(ecu_opstate_pkg::IN_COUNT)) inputSync (
        .clk    (clk),
        .arst_n (arst_n),
        .pins   (pins)
    );

    logic key;
    logic wake;
    logic v5vOk;
    logic batHigh;
    logic rtOf;
    logic pdOf;
    logic ssotOf;
    logic pdtOf;

    assign key     = pins.clean[ecu_opstate_pkg::IN_KEY];
    assign wake    = pins.clean[ecu_opstate_pkg::IN_WAKE_PIN]
                   | pins.clean[ecu_opstate_pkg::IN_CAN_WAKE]
                   | pins.clean[ecu_opstate_pkg::IN_EOT_WAKE];
    assign v5vOk   = pins.clean[ecu_opstate_pkg::IN_V5V_OK];
    assign batHigh = pins.clean[ecu_opstate_pkg::IN_BAT_HIGH];
    assign rtOf    = pins.clean[ecu_opstate_pkg::IN_RAMPUP_TIMER_OVERFLOW];
    assign pdOf    = pins.clean[ecu_opstate_pkg::IN_POWERDOWN_COUNTER_OVERFLOW];
    assign ssotOf  = pins.clean[ecu_opstate_pkg::IN_SECURE_SHUTOFF_TIMER_OVERFLOW];
    assign pdtOf   = pins.clean[ecu_opstate_pkg::IN_POWERDOWN_TIMER_OVERFLOW];

    // register index from byte address: 0 config, 1 command, 2 status, 3 unmapped
    function automatic logic [1:0] regIndex(input logic [3:0] addr);
        unique case (addr)
            ecu_opstate_pkg::ADDR_OPERATION_CONFIG: regIndex = 2'h0;
            ecu_opstate_pkg::ADDR_COMMAND_ZERO:     regIndex = 2'h1;
            ecu_opstate_pkg::ADDR_OPERATION_STATUS: regIndex = 2'h2;
            default:                                regIndex = 2'h3;
        endcase
    endfunction

    logic        opMode;
    logic [31:0] statusWord;

    assign opMode = (r_q.state == ecu_opstate_pkg::ST_NORMAL)
                  | (r_q.state == ecu_opstate_pkg::ST_AFTERRUN);

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[ecu_opstate_pkg::STAT_STATE_LSB +: 7]    = r_q.state;
        statusWord[ecu_opstate_pkg::STAT_OPERATING_MODE]    = opMode;
        statusWord[ecu_opstate_pkg::STAT_WAKE_REQUEST]      = wake;
        statusWord[ecu_opstate_pkg::STAT_MAIN_RELAY]        = r_q.relayOn;
        statusWord[ecu_opstate_pkg::STAT_KEY]               = key;
    end

    assign awready = !r_q.awHeld && !r_q.bValid;
    assign wready  = !r_q.wHeld && !r_q.bValid;
    assign arready = !r_q.rValid;

    always_comb begin
        r_d = r_q;

        // register bus: address and data may arrive in either order
        if (awvalid && awready) begin
            r_d.awHeld = 1'b1;
            r_d.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            r_d.wHeld = 1'b1;
            r_d.wData = wdata;
            r_d.wStrb = wstrb;
        end
        if (r_q.bValid && bready) begin
            r_d.bValid = 1'b0;
        end
        if (r_q.awHeld && r_q.wHeld && !r_q.bValid) begin
            r_d.awHeld = 1'b0;
            r_d.wHeld  = 1'b0;
            r_d.bValid = 1'b1;
            r_d.bResp  = ecu_opstate_pkg::RESP_OKAY;
            unique case (regIndex(r_q.awAddr))
                2'h0: begin
                    if (r_q.wStrb[0]) begin
                        r_d.afterrunEnable = r_q.wData[ecu_opstate_pkg::CFG_AFTERRUN_ENABLE];
                        r_d.afterrunReset  = r_q.wData[ecu_opstate_pkg::CFG_AFTERRUN_RESET];
                        r_d.relayRequest   = r_q.wData[ecu_opstate_pkg::CFG_MAIN_RELAY];
                    end
                end
                2'h1: begin
                    if (r_q.wStrb[0]) begin
                        r_d.wakeClearCmd = r_q.wData[ecu_opstate_pkg::CMD_WAKE_CLEAR];
                    end
                end
                2'h2: begin
                    // status is read only; the write is acknowledged and dropped
                end
                2'h3: begin
                    r_d.bResp = ecu_opstate_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (r_q.rValid && rready) begin
            r_d.rValid = 1'b0;
        end
        if (arvalid && !r_q.rValid) begin
            r_d.rValid = 1'b1;
            r_d.rResp  = ecu_opstate_pkg::RESP_OKAY;
            r_d.rData  = 32'h0000_0000;
            unique case (regIndex(araddr))
                2'h0: begin
                    r_d.rData[ecu_opstate_pkg::CFG_AFTERRUN_ENABLE] = r_q.afterrunEnable;
                    r_d.rData[ecu_opstate_pkg::CFG_AFTERRUN_RESET]  = r_q.afterrunReset;
                    r_d.rData[ecu_opstate_pkg::CFG_MAIN_RELAY]      = r_q.relayRequest;
                end
                2'h1: r_d.rData[ecu_opstate_pkg::CMD_WAKE_CLEAR] = r_q.wakeClearCmd;
                2'h2: r_d.rData = statusWord;
                2'h3: r_d.rResp = ecu_opstate_pkg::RESP_SLVERR;
            endcase
        end

        // operating state machine; seven states only
        r_d.clrCount = 3'h0;
        if (r_q.porPending) begin
            // inputs settle through the synchroniser before the reset decision
            r_d.porCount = r_q.porCount + 3'h1;
            if (r_q.porCount == ecu_opstate_pkg::POR_SETTLE_CYCLES) begin
                r_d.porPending = 1'b0;
                if (key || wake) begin
                    r_d.state = ecu_opstate_pkg::ST_RAMPUP;
                end else begin
                    r_d.state = ecu_opstate_pkg::ST_SLEEP;
                end
            end
        end else begin
            unique case (r_q.state)
                ecu_opstate_pkg::ST_SLEEP: begin
                    if (key || wake) begin
                        r_d.state = ecu_opstate_pkg::ST_RAMPUP;
                    end
                end
                ecu_opstate_pkg::ST_RAMPUP: begin
                    if (!key && !wake) begin
                        r_d.state = ecu_opstate_pkg::ST_SLEEP;
                    end else if (v5vOk) begin
                        r_d.state = ecu_opstate_pkg::ST_NORMAL;
                    end else if (!key && rtOf) begin
                        r_d.state = ecu_opstate_pkg::ST_WAKE_CLEAR;
                    end
                end
                ecu_opstate_pkg::ST_NORMAL: begin
                    if (!key && (pdOf || ssotOf)) begin
                        r_d.state = ecu_opstate_pkg::ST_POWER_DOWN;
                    end else if (!key && r_q.afterrunEnable) begin
                        r_d.state = ecu_opstate_pkg::ST_AFTERRUN;
                    end else if (!key && !wake) begin
                        r_d.state = ecu_opstate_pkg::ST_SLEEP;
                    end
                end
                ecu_opstate_pkg::ST_AFTERRUN: begin
                    if (pdOf || ssotOf) begin
                        r_d.state = ecu_opstate_pkg::ST_POWER_DOWN;
                    end else if (key && r_q.afterrunReset) begin
                        r_d.state = ecu_opstate_pkg::ST_AR_RESET;
                    end else if (key) begin
                        r_d.state = ecu_opstate_pkg::ST_NORMAL;
                    end else if (!r_q.afterrunEnable && !wake) begin
                        r_d.state = ecu_opstate_pkg::ST_SLEEP;
                    end
                end
                ecu_opstate_pkg::ST_AR_RESET: begin
                    r_d.state = ecu_opstate_pkg::ST_NORMAL;
                end
                ecu_opstate_pkg::ST_POWER_DOWN: begin
                    if (pdtOf) begin
                        r_d.state = ecu_opstate_pkg::ST_WAKE_CLEAR;
                    end
                end
                ecu_opstate_pkg::ST_WAKE_CLEAR: begin
                    // bounded wait so a stuck wake source cannot hold the state
                    r_d.clrCount = r_q.clrCount + 3'h1;
                    if (!wake || r_q.clrCount == ecu_opstate_pkg::WAKE_CLEAR_CYCLES) begin
                        r_d.clrCount = 3'h0;
                        r_d.state = key ? ecu_opstate_pkg::ST_RAMPUP
                                        : ecu_opstate_pkg::ST_SLEEP;
                    end
                end
                default: r_d.state = ecu_opstate_pkg::ST_SLEEP;
            endcase
        end

        // relay follows the state being entered
        unique case (r_d.state)
            ecu_opstate_pkg::ST_SLEEP:    r_d.relayOn = 1'b0;
            ecu_opstate_pkg::ST_RAMPUP:   r_d.relayOn = batHigh;
            ecu_opstate_pkg::ST_NORMAL,
            ecu_opstate_pkg::ST_AFTERRUN: r_d.relayOn = batHigh | r_q.relayRequest;
            default:                      r_d.relayOn = r_q.relayOn;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q                <= '0;
            r_q.state          <= ecu_opstate_pkg::ST_SLEEP;
            r_q.porPending     <= 1'b1;
            r_q.afterrunEnable <= ecu_opstate_pkg::RST_AFTERRUN_ENABLE;
            r_q.afterrunReset  <= ecu_opstate_pkg::RST_AFTERRUN_RESET;
            r_q.relayRequest   <= ecu_opstate_pkg::RST_MAIN_RELAY;
            r_q.wakeClearCmd   <= ecu_opstate_pkg::RST_WAKE_CLEAR_CMD;
        end else begin
            r_q <= r_d;
        end
    end

    logic supplied;
    assign supplied = (r_q.state == ecu_opstate_pkg::ST_RAMPUP)
                    | (r_q.state == ecu_opstate_pkg::ST_NORMAL)
                    | (r_q.state == ecu_opstate_pkg::ST_AFTERRUN)
                    | (r_q.state == ecu_opstate_pkg::ST_AR_RESET);

    assign bvalid              = r_q.bValid;
    assign bresp               = r_q.bResp;
    assign rvalid              = r_q.rValid;
    assign rdata               = r_q.rData;
    assign rresp               = r_q.rResp;
    assign mainRelayOn         = r_q.relayOn;
    assign ecu5vSupplyEn       = supplied && !r_q.porPending;
    assign trackerSupplyEn     = supplied && !r_q.porPending;
    assign externalFunctionsEn = opMode;
    assign powerdownTimerRun   = (r_q.state == ecu_opstate_pkg::ST_POWER_DOWN);
    assign wakeClearActive     = (r_q.state == ecu_opstate_pkg::ST_WAKE_CLEAR);
    assign wakeClearMode       = r_q.wakeClearCmd;
    assign afterrunResetActive = (r_q.state == ecu_opstate_pkg::ST_AR_RESET);
    assign operatingModeBit    = opMode;
    assign stateCode           = r_q.state;

    sleep_relay_a: assert property (@(posedge clk) disable iff (!arst_n)
        r_q.state == ecu_opstate_pkg::ST_SLEEP |-> !mainRelayOn)
        else $error("relay on in sleep");

    sleep_exit_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r_q.state == ecu_opstate_pkg::ST_SLEEP && !r_q.porPending && (key || wake))
        |=> r_q.state == ecu_opstate_pkg::ST_RAMPUP)
        else $error("sleep did not leave for ramp-up");

    rampup_abort_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r_q.state == ecu_opstate_pkg::ST_RAMPUP && !r_q.porPending && !key && !wake)
        |=> r_q.state == ecu_opstate_pkg::ST_SLEEP)
        else $error("ramp-up did not fall back to sleep");

    rampup_timeout_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r_q.state == ecu_opstate_pkg::ST_RAMPUP && !r_q.porPending && !key && wake
         && rtOf && !v5vOk) |=> r_q.state == ecu_opstate_pkg::ST_WAKE_CLEAR)
        else $error("ramp-up timeout missed wake clear");

    afterrun_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r_q.state == ecu_opstate_pkg::ST_NORMAL && !r_q.porPending && !key
         && r_q.afterrunEnable && !pdOf && !ssotOf)
        |=> r_q.state == ecu_opstate_pkg::ST_AFTERRUN && operatingModeBit)
        else $error("afterrun not entered");

    afterrun_resume_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r_q.state == ecu_opstate_pkg::ST_AFTERRUN && !r_q.porPending && key
         && !r_q.afterrunReset && !pdOf && !ssotOf)
        |=> r_q.state == ecu_opstate_pkg::ST_NORMAL)
        else $error("afterrun did not resume normal");

    ar_reset_single_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(afterrunResetActive) |=> !afterrunResetActive
        && r_q.state == ecu_opstate_pkg::ST_NORMAL)
        else $error("afterrun reset longer than one clock");

    power_down_a: assert property (@(posedge clk) disable iff (!arst_n)
        r_q.state == ecu_opstate_pkg::ST_POWER_DOWN
        |-> !ecu5vSupplyEn && !trackerSupplyEn && powerdownTimerRun
        && $stable(mainRelayOn))
        else $error("power down outputs wrong");

    pdt_exit_a: assert property (@(posedge clk) disable iff (!arst_n)
        (r_q.state == ecu_opstate_pkg::ST_POWER_DOWN && !r_q.porPending && pdtOf)
        |=> wakeClearActive)
        else $error("power-down timer overflow ignored");

    por_decide_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(r_q.porPending) |-> r_q.state == (($past(key) || $past(wake))
        ? ecu_opstate_pkg::ST_RAMPUP : ecu_opstate_pkg::ST_SLEEP))
        else $error("reset decision wrong");
endmodule

// [sim/ecu_supply_model.sv]
`timescale 1ns/1ps
module ecu_supply_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic supplyEn,
    input  wire logic rampFail,
    output logic      supplyOk
);
    logic [2:0] rampCnt_q;
    // slow ramp: the rail is good only after several cycles of enable, never while shorted
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            rampCnt_q <= 3'h0;
        else if (!supplyEn || rampFail)
            rampCnt_q <= 3'h0;
        else if (rampCnt_q != 3'h7)
            rampCnt_q <= rampCnt_q + 3'h1;
    end
    assign supplyOk = (rampCnt_q == 3'h7);
endmodule

// [sim/ecu_operation_state_machine_tb.sv]
`timescale 1ns/1ps
module ecu_operation_state_machine_tb;
    logic        clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, rampFail = 1'b0, keyAboveThreshold = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0]  bresp, rresp, rr;
    logic [6:0]  stateCode;
    logic        pinWakeSignal = 1'b0, canWakeSignal = 1'b0, engineOffTimerWake = 1'b0;
    logic        batterySupplyHigh = 1'b1, rampupTimerOverflow = 1'b0;
    logic        powerdownCounterOverflow = 1'b0, secureShutoffTimerOverflow = 1'b0;
    logic        powerdownTimerOverflow = 1'b0, ecu5vSupplyOk, awready, wready, bvalid;
    logic        arready, rvalid, mainRelayOn, ecu5vSupplyEn, trackerSupplyEn;
    logic        externalFunctionsEn, powerdownTimerRun, wakeClearActive, wakeClearMode;
    logic        afterrunResetActive, operatingModeBit;
    int          errorCnt = 0, checkCount = 0, cycles = 0, arCount = 0;

    ecu_operation_state_machine u_ecu_operation_state_machine (.*);
    ecu_supply_model u_ecu_supply_model (.clk(clk), .arst_n(arst_n), .supplyEn(ecu5vSupplyEn),
                                         .rampFail(rampFail), .supplyOk(ecu5vSupplyOk));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (afterrunResetActive === 1'b1)
            arCount++;
        if (cycles == 6000) begin
            errorCnt++;
            printVerdict();
        end
    end

    task automatic printVerdict();
        $display("checks %0d errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // inputs pass a synchroniser, so the state is polled rather than timed
    task automatic expectState(input logic [6:0] s);
        int n;
        n = 0;
        while (stateCode !== s && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(stateCode, s);
    endtask

    // readies are sampled at the falling edge, where they are settled for the next rising edge
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
        logic awGo, wGo;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge clk);
            awGo = awvalid && awready;
            wGo = wvalid && wready;
            @(posedge clk);
            if (awGo) awvalid <= 1'b0;
            if (wGo) wvalid <= 1'b0;
        end while (!(awGo && wGo) && (awvalid || wvalid));
        do @(negedge clk); while (bvalid !== 1'b1);
        rr = bresp;
        @(posedge clk) bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [3:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk) arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        @(posedge clk) rready <= 1'b0;
    endtask

    task automatic testKeyAfterrun();
        check(stateCode, ecu_opstate_pkg::ST_SLEEP);
        check(mainRelayOn, 1'b0);
        axiRead(4'hC);
        check(rr, ecu_opstate_pkg::RESP_SLVERR);
        axiWrite(ecu_opstate_pkg::ADDR_OPERATION_CONFIG, 32'h3);
        keyAboveThreshold <= 1'b1;
        expectState(ecu_opstate_pkg::ST_RAMPUP);
        expectState(ecu_opstate_pkg::ST_NORMAL);
        axiRead(ecu_opstate_pkg::ADDR_OPERATION_STATUS);
        check(rd, 32'hD04);
        check(mainRelayOn, 1'b1);
        keyAboveThreshold <= 1'b0;
        expectState(ecu_opstate_pkg::ST_AFTERRUN);
        check(ecu5vSupplyEn, 1'b1);
        check({externalFunctionsEn, operatingModeBit}, 2'h3);
        @(posedge clk) keyAboveThreshold <= 1'b1;
        expectState(ecu_opstate_pkg::ST_AR_RESET);
        @(negedge clk);
        check(stateCode, ecu_opstate_pkg::ST_NORMAL);
    endtask

    task automatic testShutdown();
        axiWrite(ecu_opstate_pkg::ADDR_OPERATION_CONFIG, 32'h5);
        keyAboveThreshold <= 1'b0;
        batterySupplyHigh <= 1'b0;
        expectState(ecu_opstate_pkg::ST_AFTERRUN);
        check(mainRelayOn, 1'b1);
        @(posedge clk) keyAboveThreshold <= 1'b1;
        expectState(ecu_opstate_pkg::ST_NORMAL);
        @(posedge clk) keyAboveThreshold <= 1'b0;
        expectState(ecu_opstate_pkg::ST_AFTERRUN);
        axiWrite(ecu_opstate_pkg::ADDR_OPERATION_CONFIG, 32'h0);
        expectState(ecu_opstate_pkg::ST_SLEEP);
        @(negedge clk);
        check(mainRelayOn, 1'b0);
    endtask

    task automatic testRampFailures();
        axiWrite(ecu_opstate_pkg::ADDR_COMMAND_ZERO, 32'h1);
        check(rr, ecu_opstate_pkg::RESP_OKAY);
        check(wakeClearMode, 1'b1);
        axiWrite(4'hC, 32'h1);
        check(rr, ecu_opstate_pkg::RESP_SLVERR);
        @(posedge clk) rampFail <= 1'b1;
        pinWakeSignal <= 1'b1;
        batterySupplyHigh <= 1'b1;
        expectState(ecu_opstate_pkg::ST_RAMPUP);
        @(posedge clk) pinWakeSignal <= 1'b0;
        expectState(ecu_opstate_pkg::ST_SLEEP);
        @(posedge clk) canWakeSignal <= 1'b1;
        expectState(ecu_opstate_pkg::ST_RAMPUP);
        @(posedge clk) rampupTimerOverflow <= 1'b1;
        expectState(ecu_opstate_pkg::ST_WAKE_CLEAR);
        check(wakeClearActive, 1'b1);
        @(posedge clk) canWakeSignal <= 1'b0;
        rampupTimerOverflow <= 1'b0;
        rampFail <= 1'b0;
        expectState(ecu_opstate_pkg::ST_SLEEP);
    endtask

    task automatic testPowerDown();
        @(posedge clk) engineOffTimerWake <= 1'b1;
        expectState(ecu_opstate_pkg::ST_NORMAL);
        @(posedge clk) secureShutoffTimerOverflow <= 1'b1;
        expectState(ecu_opstate_pkg::ST_POWER_DOWN);
        check({ecu5vSupplyEn, trackerSupplyEn, externalFunctionsEn, powerdownTimerRun,
               mainRelayOn}, 5'h03);
        @(posedge clk) secureShutoffTimerOverflow <= 1'b0;
        engineOffTimerWake <= 1'b0;
        keyAboveThreshold <= 1'b1;
        powerdownTimerOverflow <= 1'b1;
        expectState(ecu_opstate_pkg::ST_WAKE_CLEAR);
        @(posedge clk) powerdownTimerOverflow <= 1'b0;
        expectState(ecu_opstate_pkg::ST_RAMPUP);
        expectState(ecu_opstate_pkg::ST_NORMAL);
        @(posedge clk) arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check(stateCode, ecu_opstate_pkg::ST_SLEEP);
        arst_n <= 1'b1;
        expectState(ecu_opstate_pkg::ST_RAMPUP);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        testKeyAfterrun();
        testShutdown();
        testRampFailures();
        testPowerDown();
        check(arCount, 1);
        printVerdict();
    end
endmodule
